// >>> hdl/civ_pkg.sv
// Constants, types and source table layout of the interrupt vector encoder
//------------------------------------------------------------------
// Contract
//------------------------------------------------------------------
package civ_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_MAIN_CFG   = 8'h80;
  localparam logic [7:0] OFS_POS_TYPE   = 8'h84;
  localparam logic [7:0] OFS_TASK_TYPE  = 8'h88;
  localparam logic [7:0] OFS_C_ORDER    = 8'h98;
  localparam logic [7:0] OFS_MASK_LO    = 8'ha0;
  localparam logic [7:0] OFS_MASK_HI    = 8'ha4;
  localparam logic [7:0] OFS_LOW_VEC    = 8'hb0;
  localparam logic [7:0] OFS_HIGH_VEC   = 8'hb4;

  // Writable bits; bit 0 of the documented numbering is the word MSB
  localparam logic [31:0] MAIN_CFG_WMASK  = 32'h3f6f0300;
  localparam logic [31:0] POS_TYPE_WMASK  = 32'hf0f0f0f0;
  localparam logic [31:0] TASK_TYPE_WMASK = 32'hf0f00000;
  localparam logic [31:0] C_ORDER_WMASK   = 32'hfff0fff0;

  // Reset values
  localparam logic [31:0] MAIN_CFG_RST  = 32'h00000000;
  localparam logic [31:0] POS_TYPE_RST  = 32'h00000000;
  localparam logic [31:0] TASK_TYPE_RST = 32'h00000000;
  localparam logic [31:0] C_ORDER_RST   = 32'h05309770;
  localparam logic [63:0] MASK_RST      = 64'h0000000000000000;

  // Field positions in the main configuration word
  localparam int TOP_NUM_MSB  = 29;
  localparam int TASK_B_LAY   = 22;
  localparam int TASK_A_LAY   = 21;
  localparam int GRP_D_LAY    = 19;
  localparam int GRP_C_LAY    = 18;
  localparam int GRP_A_LAY    = 17;
  localparam int GRP_B_LAY    = 16;
  localparam int TOP_SEL_MSB  = 9;

  // Output type codes
  localparam logic [1:0] TYPE_LOW  = 2'h0;
  localparam logic [1:0] TYPE_HIGH = 2'h2;

  // Vector codes
  localparam logic [5:0] VEC_NONE = 6'h00;

  // Slot groups, in grouped ranking order
  localparam logic [2:0] GRP_TASK_A = 3'h0;
  localparam logic [2:0] GRP_A      = 3'h1;
  localparam logic [2:0] GRP_TASK_B = 3'h2;
  localparam logic [2:0] GRP_B      = 3'h3;
  localparam logic [2:0] GRP_C      = 3'h4;
  localparam logic [2:0] GRP_D      = 3'h5;

  typedef struct packed {
    logic       valid;
    logic [2:0] grp;
    logic [2:0] pos;
  } civ_src_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wrData;
    logic        wrStb;
    logic        rdStb;
  } civ_bus_type;

  typedef struct packed {
    logic [31:0] mainCfg;
    logic [31:0] posType;
    logic [31:0] taskType;
    logic [31:0] cOrder;
    logic [63:0] mask;
    logic [31:0] rdData;
    logic        reqLow;
    logic        reqHigh;
  } civ_state_type;

endpackage

// >>> hdl/civ_vector_encoder.sv
// Vector encoder and routing configuration of the engine interrupt controller
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
module civ_vector_encoder #(
  parameter int SRC_COUNT = 64
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire civ_pkg::civ_bus_type bus,
  input  wire logic [63:0]          pending,
  output logic [31:0]               rdData,
  output logic                      reqLow,
  output logic                      reqHigh
);

  //----------------------------------------------------------------
  // Parameter check
  //----------------------------------------------------------------
  if (SRC_COUNT != 64) begin : g_bad_count
    $error("Vector table holds exactly 64 source numbers");
  end

  //----------------------------------------------------------------
  // Source table
  //----------------------------------------------------------------
  // Slot position of a source; group C positions follow the order register
  function automatic civ_pkg::civ_src_type srcInfo(input logic [5:0]  num,
                                                   input logic [31:0] order);
    civ_pkg::civ_src_type s;
    logic [2:0]           code;
    logic [2:0]           field;
    s = '0;
    code = 3'h0;
    case (num)
      6'h01: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_C; code = 3'h0; end
      6'h02: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_C; code = 3'h1; end
      6'h03: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_C; code = 3'h2; end
      6'h0a: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_D; s.pos = 3'h1; end
      6'h0b: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_D; s.pos = 3'h2; end
      6'h0c: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_D; s.pos = 3'h3; end
      6'h0d: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_D; s.pos = 3'h4; end
      6'h0e: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_D; s.pos = 3'h5; end
      6'h0f: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_D; s.pos = 3'h6; end
      6'h11: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_TASK_A; s.pos = 3'h0; end
      6'h14: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_TASK_A; s.pos = 3'h3; end
      6'h15: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_TASK_A; s.pos = 3'h4; end
      6'h19: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_TASK_B; s.pos = 3'h0; end
      6'h1a: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_TASK_B; s.pos = 3'h1; end
      6'h1b: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_TASK_B; s.pos = 3'h2; end
      6'h1c: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_TASK_B; s.pos = 3'h3; end
      6'h20: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_A; s.pos = 3'h0; end
      6'h21: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_A; s.pos = 3'h1; end
      6'h22: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_A; s.pos = 3'h2; end
      6'h24: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_A; s.pos = 3'h4; end
      6'h28: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_B; s.pos = 3'h0; end
      6'h2a: begin s.valid = 1'b1; s.grp = civ_pkg::GRP_B; s.pos = 3'h2; end
      default: s = '0;
    endcase
    // A group C source not placed in any position never requests
    if (s.valid && s.grp == civ_pkg::GRP_C) begin
      s.valid = 1'b0;
      for (int k = 7; k >= 0; k--) begin
        field = (k < 4) ? order[31 - 3 * k -: 3] : order[15 - 3 * (k - 4) -: 3];
        if (field == code) begin
          s.valid = 1'b1;
          s.pos   = 3'(k);
        end
      end
    end
    return s;
  endfunction

  // Rank in the priority table; lower wins
  function automatic logic [6:0] rankOf(input civ_pkg::civ_src_type s,
                                        input logic [31:0]          cfg);
    logic spread;
    case (s.grp)
      civ_pkg::GRP_TASK_A: spread = cfg[civ_pkg::TASK_A_LAY];
      civ_pkg::GRP_TASK_B: spread = cfg[civ_pkg::TASK_B_LAY];
      civ_pkg::GRP_A:      spread = cfg[civ_pkg::GRP_A_LAY];
      civ_pkg::GRP_B:      spread = cfg[civ_pkg::GRP_B_LAY];
      civ_pkg::GRP_C:      spread = cfg[civ_pkg::GRP_C_LAY];
      default:             spread = cfg[civ_pkg::GRP_D_LAY];
    endcase
    return spread ? {1'b1, s.pos, s.grp} : {1'b0, s.grp, s.pos};
  endfunction

  // High output for a source position
  function automatic logic isHigh(input civ_pkg::civ_src_type s,
                                  input logic [31:0]          posT,
                                  input logic [31:0]          taskT);
    logic [1:0] f;
    int         base;
    f = civ_pkg::TYPE_LOW;
    base = 0;
    if (s.pos < 3'h2) begin
      case (s.grp)
        civ_pkg::GRP_D:      base = 0;
        civ_pkg::GRP_C:      base = 8;
        civ_pkg::GRP_B:      base = 16;
        civ_pkg::GRP_A:      base = 24;
        civ_pkg::GRP_TASK_B: base = 0;
        default:             base = 8;
      endcase
      base = base + 2 * int'(s.pos);
      if (s.grp == civ_pkg::GRP_TASK_A || s.grp == civ_pkg::GRP_TASK_B) begin
        f = taskT[31 - base -: 2];
      end else begin
        f = posT[31 - base -: 2];
      end
    end
    return f == civ_pkg::TYPE_HIGH;
  endfunction

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  civ_pkg::civ_state_type st;
  civ_pkg::civ_state_type next_st;
  logic [5:0]             vecLow;
  logic [5:0]             vecHigh;
  logic [5:0]             topNum;
  logic                   topToHigh;

  assign topNum    = st.mainCfg[civ_pkg::TOP_NUM_MSB -: 6];
  assign topToHigh = st.mainCfg[civ_pkg::TOP_SEL_MSB -: 2] == civ_pkg::TYPE_HIGH;

  //----------------------------------------------------------------
  // Selection
  //----------------------------------------------------------------
  // Combinational so that a vector read sees pending and mask of that cycle
  always_comb begin
    civ_pkg::civ_src_type s;
    logic [6:0]           bestLow;
    logic [6:0]           bestHigh;
    logic [6:0]           r;
    logic                 live;
    logic                 toHigh;
    logic                 topLow;
    logic                 topHigh;
    s = '0;
    bestLow = '1;
    bestHigh = '1;
    r = '0;
    live = 1'b0;
    toHigh = 1'b0;
    topLow = 1'b0;
    topHigh = 1'b0;
    vecLow = civ_pkg::VEC_NONE;
    vecHigh = civ_pkg::VEC_NONE;
    for (int i = 0; i < SRC_COUNT; i++) begin
      s = srcInfo(6'(i), st.cOrder);
      live = s.valid && pending[i] && st.mask[i];
      r = rankOf(s, st.mainCfg);
      toHigh = isHigh(s, st.posType, st.taskType);
      if (live && 6'(i) == topNum) begin
        if (topToHigh) begin
          topHigh = 1'b1;
          vecHigh = 6'(i);
        end else begin
          topLow = 1'b1;
          vecLow = 6'(i);
        end
      end else if (live) begin
        if (toHigh) begin
          if (!topHigh && r < bestHigh) begin
            bestHigh = r;
            vecHigh = 6'(i);
          end
        end else if (!topLow && r < bestLow) begin
          bestLow = r;
          vecLow = 6'(i);
        end
      end
    end
  end

  //----------------------------------------------------------------
  // Register file and outputs
  //----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdData = 32'h00000000;
    if (bus.wrStb) begin
      unique case (bus.addr)
        civ_pkg::OFS_MAIN_CFG:  next_st.mainCfg = bus.wrData & civ_pkg::MAIN_CFG_WMASK;
        civ_pkg::OFS_POS_TYPE:  next_st.posType = bus.wrData & civ_pkg::POS_TYPE_WMASK;
        civ_pkg::OFS_TASK_TYPE: next_st.taskType = bus.wrData & civ_pkg::TASK_TYPE_WMASK;
        civ_pkg::OFS_C_ORDER:   next_st.cOrder = bus.wrData & civ_pkg::C_ORDER_WMASK;
        civ_pkg::OFS_MASK_LO:   next_st.mask[31:0] = bus.wrData;
        civ_pkg::OFS_MASK_HI:   next_st.mask[63:32] = bus.wrData;
        default:                next_st.mask = st.mask;
      endcase
    end
    if (bus.rdStb) begin
      unique case (bus.addr)
        civ_pkg::OFS_MAIN_CFG:  next_st.rdData = st.mainCfg;
        civ_pkg::OFS_POS_TYPE:  next_st.rdData = st.posType;
        civ_pkg::OFS_TASK_TYPE: next_st.rdData = st.taskType;
        civ_pkg::OFS_C_ORDER:   next_st.rdData = st.cOrder;
        civ_pkg::OFS_MASK_LO:   next_st.rdData = st.mask[31:0];
        civ_pkg::OFS_MASK_HI:   next_st.rdData = st.mask[63:32];
        civ_pkg::OFS_LOW_VEC:   next_st.rdData = {26'h0000000, vecLow};
        civ_pkg::OFS_HIGH_VEC:  next_st.rdData = {26'h0000000, vecHigh};
        default:                next_st.rdData = 32'h00000000;
      endcase
    end
    next_st.reqLow = vecLow != civ_pkg::VEC_NONE;
    next_st.reqHigh = vecHigh != civ_pkg::VEC_NONE;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st.mainCfg  <= civ_pkg::MAIN_CFG_RST;
      st.posType  <= civ_pkg::POS_TYPE_RST;
      st.taskType <= civ_pkg::TASK_TYPE_RST;
      st.cOrder   <= civ_pkg::C_ORDER_RST;
      st.mask     <= civ_pkg::MASK_RST;
      st.rdData   <= 32'h00000000;
      st.reqLow   <= 1'b0;
      st.reqHigh  <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign rdData  = st.rdData;
  assign reqLow  = st.reqLow;
  assign reqHigh = st.reqHigh;

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  no_request_zero_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus.rdStb && bus.addr == civ_pkg::OFS_LOW_VEC && (pending & st.mask) == 64'h0
      |=> rdData == 32'h00000000)
    else $error("Low vector not zero with no request");

  spi_vector_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus.rdStb && bus.addr == civ_pkg::OFS_LOW_VEC && (pending & st.mask) == 64'h2
      && topNum != 6'h01 |=> rdData == 32'h00000001 || rdData == 32'h00000000)
    else $error("Second SPI source gave wrong vector");

  vector_legal_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      vecLow != civ_pkg::VEC_NONE |-> srcInfo(vecLow, st.cOrder).valid
      && pending[vecLow] && st.mask[vecLow])
    else $error("Vector names a reserved or idle source");

  masked_silent_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      (pending & st.mask) == 64'h0 |=> !reqLow && !reqHigh)
    else $error("Request with every source masked");

  top_wins_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      pending[topNum] && st.mask[topNum] && srcInfo(topNum, st.cOrder).valid
      && !topToHigh |-> vecLow == topNum)
    else $error("Promoted source not chosen on low output");

  top_high_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      pending[topNum] && st.mask[topNum] && srcInfo(topNum, st.cOrder).valid
      && topToHigh |=> reqHigh)
    else $error("Promoted source did not reach high output");

  type_unused_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus.rdStb && bus.addr == civ_pkg::OFS_POS_TYPE
      |=> (rdData & ~civ_pkg::POS_TYPE_WMASK) == 32'h00000000)
    else $error("Unused type bits read nonzero");

  top_write_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      bus.wrStb && bus.addr == civ_pkg::OFS_MAIN_CFG
      |=> topNum == $past(bus.wrData[civ_pkg::TOP_NUM_MSB -: 6]))
    else $error("Top source field did not take the write");

  req_follows_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      vecLow != civ_pkg::VEC_NONE |=> reqLow)
    else $error("Low request missing for a live source");

  late_position_low_a:
    assert property (@(posedge clk) disable iff (!rst_n)
      vecHigh != civ_pkg::VEC_NONE && vecHigh != topNum
      |-> srcInfo(vecHigh, st.cOrder).pos < 3'h2)
    else $error("Late slot position routed high");

endmodule // civ_vector_encoder

// >>> tb/civ_core_model.sv
// Far-side model: system interrupt controller that latches request levels
`timescale 1ns/1ns
module civ_core_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic reqLow,
  input  wire logic reqHigh,
  input  wire logic clearSeen,
  output logic      lowSeen,
  output logic      highSeen
);
  // ------------------------------------------------------------
  // Sticky request capture
  // ------------------------------------------------------------
  // Sticky flags let the bench catch a one-cycle glitch it did not sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowSeen  <= 1'b0;
      highSeen <= 1'b0;
    end else if (clearSeen) begin
      lowSeen  <= 1'b0;
      highSeen <= 1'b0;
    end else begin
      lowSeen  <= lowSeen | reqLow;
      highSeen <= highSeen | reqHigh;
    end
  end
endmodule // civ_core_model

// >>> tb/tb_comms_engine_irq_vector_config.sv
// Self-checking bench of the interrupt vector encoder
`timescale 1ns/1ns
module tb_comms_engine_irq_vector_config;
  typedef struct packed {
    logic [5:0] idx;
    logic [5:0] vec;
  } civ_row_type;

  logic                 clk       = 1'b0;
  logic                 rst_n     = 1'b0;
  civ_pkg::civ_bus_type bus       = '0;
  logic [63:0]          pending   = 64'h0;
  logic                 clearSeen = 1'b0;
  logic [31:0]          rdData;
  logic                 reqLow;
  logic                 reqHigh;
  logic                 lowSeen;
  logic                 highSeen;
  logic [31:0]          got;
  int                   num_errors = 0;
  int                   checks     = 0;
  int                   cycles     = 0;
  // Reserved numbers expect vector VEC_NONE (0) and no request
  civ_row_type          rows [26] = '{
    '{6'h01, 6'h01}, '{6'h02, 6'h02}, '{6'h03, 6'h03}, '{6'h0a, 6'h0a}, '{6'h0b, 6'h0b},
    '{6'h0c, 6'h0c}, '{6'h0d, 6'h0d}, '{6'h0e, 6'h0e}, '{6'h0f, 6'h0f}, '{6'h11, 6'h11},
    '{6'h14, 6'h14}, '{6'h15, 6'h15}, '{6'h19, 6'h19}, '{6'h1a, 6'h1a}, '{6'h1b, 6'h1b},
    '{6'h1c, 6'h1c}, '{6'h20, 6'h20}, '{6'h21, 6'h21}, '{6'h22, 6'h22}, '{6'h24, 6'h24},
    '{6'h28, 6'h28}, '{6'h2a, 6'h2a}, '{6'h04, 6'h00}, '{6'h10, 6'h00}, '{6'h23, 6'h00},
    '{6'h3f, 6'h00}};

  civ_vector_encoder civ_vector_encoder_inst (
    .clk     (clk),
    .rst_n   (rst_n),
    .bus     (bus),
    .pending (pending),
    .rdData  (rdData),
    .reqLow  (reqLow),
    .reqHigh (reqHigh)
  );

  civ_core_model civ_core_model_inst (
    .clk       (clk),
    .rst_n     (rst_n),
    .reqLow    (reqLow),
    .reqHigh   (reqHigh),
    .clearSeen (clearSeen),
    .lowSeen   (lowSeen),
    .highSeen  (highSeen)
  );

  always #4 clk = ~clk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under 2000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
    @(posedge clk);
    bus.wrStb <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wrData: 32'h0, wrStb: 1'b0, rdStb: 1'b1};
    @(posedge clk);
    bus.rdStb <= 1'b0;
    #1;
    got = rdData;
    chk(name, exp, got);
  endtask

  task automatic masks(input logic [31:0] v);
    wr(civ_pkg::OFS_MASK_LO, v);
    wr(civ_pkg::OFS_MASK_HI, v);
  endtask

  task automatic setp(input logic [63:0] v);
    @(posedge clk);
    pending <= v;
  endtask

  // Requests trail their cause by one cycle; vectors are read afterwards
  task automatic expect_out(input logic [5:0] lo, input logic [5:0] hi,
                            input logic rl, input logic rh);
    repeat (2) @(posedge clk);
    #1;
    chk("reqLow", {31'h0, rl}, {31'h0, reqLow});
    chk("reqHigh", {31'h0, rh}, {31'h0, reqHigh});
    rdchk("lowVector", civ_pkg::OFS_LOW_VEC, {26'h0, lo});
    rdchk("highVector", civ_pkg::OFS_HIGH_VEC, {26'h0, hi});
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("mainCfg", civ_pkg::OFS_MAIN_CFG, civ_pkg::MAIN_CFG_RST);
    rdchk("posType", civ_pkg::OFS_POS_TYPE, civ_pkg::POS_TYPE_RST);
    rdchk("taskType", civ_pkg::OFS_TASK_TYPE, civ_pkg::TASK_TYPE_RST);
    rdchk("cOrder", civ_pkg::OFS_C_ORDER, civ_pkg::C_ORDER_RST);
    rdchk("maskLo", civ_pkg::OFS_MASK_LO, 32'h0);
    rdchk("unmapped", 8'h90, 32'h0);
    expect_out(6'h00, 6'h00, 1'b0, 1'b0);
    wr(civ_pkg::OFS_POS_TYPE, 32'hffffffff);
    rdchk("posType", civ_pkg::OFS_POS_TYPE, civ_pkg::POS_TYPE_WMASK);
    wr(civ_pkg::OFS_POS_TYPE, 32'h0);
    wr(civ_pkg::OFS_MAIN_CFG, 32'hffffffff);
    rdchk("mainCfg", civ_pkg::OFS_MAIN_CFG, civ_pkg::MAIN_CFG_WMASK);
    wr(civ_pkg::OFS_MAIN_CFG, 32'h0);
    $display("test registers done");

    masks(32'hffffffff);
    clearSeen <= 1'b1;
    @(posedge clk);
    clearSeen <= 1'b0;
    for (int i = 0; i < 26; i++) begin
      setp(64'h1 << rows[i].idx);
      expect_out(rows[i].vec, 6'h00, rows[i].vec != 6'h00, 1'b0);
      rdchk("vectorMap", civ_pkg::OFS_LOW_VEC, {26'h0, rows[i].vec});
    end
    chk("highSeen", 32'h0, {31'h0, highSeen});
    chk("lowSeen", 32'h1, {31'h0, lowSeen});
    $display("test vector table done");

    setp(64'h0000000100000002);
    expect_out(6'h20, 6'h00, 1'b1, 1'b0);
    wr(civ_pkg::OFS_MAIN_CFG, 32'h01000000);
    expect_out(6'h01, 6'h00, 1'b1, 1'b0);
    wr(civ_pkg::OFS_MAIN_CFG, 32'h01000200);
    expect_out(6'h20, 6'h01, 1'b1, 1'b1);
    wr(civ_pkg::OFS_MAIN_CFG, 32'h0);
    $display("test promotion done");

    // Sources masked around the type change so nothing fires mid-update
    masks(32'h0);
    wr(civ_pkg::OFS_POS_TYPE, 32'h00000080);
    wr(civ_pkg::OFS_TASK_TYPE, 32'h00800000);
    masks(32'hffffffff);
    setp(64'h0000000500000000);
    expect_out(6'h22, 6'h20, 1'b1, 1'b1);
    setp(64'h0000000000020000);
    expect_out(6'h00, 6'h11, 1'b0, 1'b1);
    masks(32'h0);
    wr(civ_pkg::OFS_POS_TYPE, 32'h0);
    wr(civ_pkg::OFS_TASK_TYPE, 32'h0);
    $display("test output type done");

    setp(64'h0000000000000002);
    expect_out(6'h00, 6'h00, 1'b0, 1'b0);
    wr(civ_pkg::OFS_MASK_LO, 32'h00000002);
    expect_out(6'h01, 6'h00, 1'b1, 1'b0);
    $display("test masking done");

    masks(32'hffffffff);
    setp(64'h0000010002000000);
    expect_out(6'h19, 6'h00, 1'b1, 1'b0);
    masks(32'h0);
    wr(civ_pkg::OFS_MAIN_CFG, 32'h1 << civ_pkg::TASK_B_LAY);
    masks(32'hffffffff);
    expect_out(6'h28, 6'h00, 1'b1, 1'b0);
    masks(32'h0);
    wr(civ_pkg::OFS_MAIN_CFG, 32'h1 << civ_pkg::GRP_A_LAY);
    masks(32'hffffffff);
    setp(64'h0000000100000002);
    expect_out(6'h01, 6'h00, 1'b1, 1'b0);
    $display("test layout done");

    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("mainCfg", civ_pkg::OFS_MAIN_CFG, civ_pkg::MAIN_CFG_RST);
    expect_out(6'h00, 6'h00, 1'b0, 1'b0);
    $display("test second reset done");
    report_and_stop();
  end
endmodule // tb_comms_engine_irq_vector_config
